// ---- pkg/pcsr_pkg.sv ----
// Purpose: Shared constants and carrier types for the PCI status register bank
// Assumes: One clock (core_clk), asynchronous active-low reset
// Notes:   Byte offsets are configuration-space byte addresses
package pcsr_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0]  PCSR_STATUS_OFFSET = 8'h06;
   localparam logic [15:0] PCSR_STATUS_RESET  = 16'h0210;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PCSR_BIT_DETECTED_PARITY = 15;
   localparam int PCSR_BIT_SIGNALED_SERR   = 14;
   localparam int PCSR_BIT_RCVD_RECEIVED_MASTER_ABORT_FLAG     = 13;
   localparam int PCSR_BIT_RCVD_TABORT     = 12;
   localparam int PCSR_BIT_SIG_TABORT      = 11;
   localparam int PCSR_BIT_DEVSEL_LO       = 9;
   localparam int PCSR_BIT_MASTER_DPAR     = 8;
   localparam int PCSR_BIT_BACK_TO_BACK    = 7;
   localparam int PCSR_BIT_USER_FEATURE    = 6;
   localparam int PCSR_BIT_DOUBLE_SPEED    = 5;
   localparam int PCSR_BIT_CAP_LIST        = 4;

   // ****************************************************************
   // Hardwired field values and masks
   // ****************************************************************
   localparam logic [1:0]  PCSR_DEVSEL_MEDIUM      = 2'h1;
   localparam logic        PCSR_BACK_TO_BACK_VAL   = 1'b0;
   localparam logic        PCSR_USER_FEATURE_VAL   = 1'b0;
   localparam logic        PCSR_DOUBLE_SPEED_VAL   = 1'b0;
   localparam logic        PCSR_CAP_LIST_VAL       = 1'b1;
   localparam logic [3:0]  PCSR_RESERVED_VAL       = 4'h0;
   localparam logic [15:0] PCSR_FLAG_MASK          = 16'hF900;
   localparam logic [15:0] PCSR_FIXED_MASK         = 16'h06FF;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   // Bus events reported by the surrounding PCI interface logic
   typedef struct packed {
      logic addr_parity_err;   // Address-phase parity error seen
      logic data_parity_err;   // Data-phase parity error seen
      logic serr_signaled;     // System error driven to host
      logic master_abort;      // Own master cycle ended by master abort
      logic target_abort_rcvd; // Own master cycle ended by target abort
      logic target_abort_sig;  // Own target cycle ended with target abort
      logic perr_seen;         // Parity error line asserted by any agent
      logic bus_master_xfer;   // Device is master of current data transfer
   } pcsr_event_t;

   // Configuration access request
   typedef struct packed {
      logic        rd;      // Read strobe, one cycle
      logic        wr;      // Write strobe, one cycle
      logic [7:0]  addr;    // Byte address
      logic [1:0]  byte_en; // Active-high byte enables
      logic [15:0] wdata;   // Write data
   } pcsr_cfg_req_t;

endpackage : pcsr_pkg

// ---- core/pcsr_flag_cell.sv ----
// Purpose: One sticky event flag cleared by writing one
// Assumes: Set and clear come from logic on the same clock
// Notes:   Set has priority over clear in the same cycle
module pcsr_flag_cell (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // Control
   input  wire logic set,
   input  wire logic clr,
   // State
   output logic      flag_q
);
   import pcsr_pkg::*;

   // Sticky flag, event beats a simultaneous clear
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_q <= 1'b0;
      end else if (set) begin
         flag_q <= 1'b1;
      end else if (clr) begin
         flag_q <= 1'b0;
      end
   end

endmodule : pcsr_flag_cell

// ---- core/pcsr_status_reg.sv ----
// Purpose: PCI configuration status register with sticky error flags
// Assumes: Events and config strobes are synchronous to core_clk
// Notes:   Read data answers one cycle after the read strobe

// Functional notes
// - Bit 15 sets on any detected address or data parity error.
// - Bit 14 sets only when system error enabled and actually signaled.
// - Bit 13 sets when own master cycle ends in master abort.
// - Bit 12 sets when own master cycle ends in target abort.
// - Bit 11 sets when device as target signals target abort.
// - Bits 10-9 read fixed 01b medium select timing; writes ignored.
// - Bit 8 sets on parity line, device master, and parity response enabled.
// - Bit 7 reads 0, no fast back-to-back acceptance.
// - Bit 6 reads 0, no user-definable features.
// - Bit 5 reads 0, not double-speed capable.
// - Bit 4 reads 1, capabilities list present.
// - Bits 3-0 read zero, writes ignored.
// - Writing one clears a flag; zero and reads leave it alone.
// - Register reads 0210h after reset, all flags clear.
module pcsr_status_reg (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    arst_n,
   // Command register enables
   input  wire logic                    system_error_enable,
   input  wire logic                    parity_response_enable,
   // Bus events
   input  wire pcsr_pkg::pcsr_event_t   events,
   // Configuration access
   input  wire pcsr_pkg::pcsr_cfg_req_t cfg_req,
   output logic                         cfg_rvalid_q,
   output logic [15:0]                  cfg_rdata_q,
   // Register view
   output logic [15:0]                  status_word_q
);
   import pcsr_pkg::*;

   // ****************************************************************
   // Decode and event qualification
   // ****************************************************************
   logic        hit;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic [15:0] flags;
   logic [15:0] fixed_bits;
   logic [15:0] status_d;

   // Address match on the status halfword
   assign hit = (cfg_req.addr[7:1] == PCSR_STATUS_OFFSET[7:1]);

   // Per-bit event sources
   always_comb begin
      set_vec = 16'h0000;
      set_vec[PCSR_BIT_DETECTED_PARITY] = events.addr_parity_err
                                        | events.data_parity_err;
      set_vec[PCSR_BIT_SIGNALED_SERR]   = events.serr_signaled
                                        & system_error_enable;
      set_vec[PCSR_BIT_RCVD_RECEIVED_MASTER_ABORT_FLAG]     = events.master_abort;
      set_vec[PCSR_BIT_RCVD_TABORT]     = events.target_abort_rcvd;
      set_vec[PCSR_BIT_SIG_TABORT]      = events.target_abort_sig;
      set_vec[PCSR_BIT_MASTER_DPAR]     = events.perr_seen
                                        & events.bus_master_xfer
                                        & parity_response_enable;
   end

   // Write-one-to-clear, flags all sit in the upper byte lane
   always_comb begin
      clr_vec = 16'h0000;
      if (cfg_req.wr && hit) begin
         clr_vec[15:8] = cfg_req.wdata[15:8] & {8{cfg_req.byte_en[1]}};
         clr_vec[7:0]  = cfg_req.wdata[7:0] & {8{cfg_req.byte_en[0]}};
      end
   end

   // Hardwired read-only fields
   always_comb begin
      fixed_bits = 16'h0000;
      fixed_bits[PCSR_BIT_DEVSEL_LO+1:PCSR_BIT_DEVSEL_LO] = PCSR_DEVSEL_MEDIUM;
      fixed_bits[PCSR_BIT_BACK_TO_BACK] = PCSR_BACK_TO_BACK_VAL;
      fixed_bits[PCSR_BIT_USER_FEATURE] = PCSR_USER_FEATURE_VAL;
      fixed_bits[PCSR_BIT_DOUBLE_SPEED] = PCSR_DOUBLE_SPEED_VAL;
      fixed_bits[PCSR_BIT_CAP_LIST]     = PCSR_CAP_LIST_VAL;
      fixed_bits[3:0]                   = PCSR_RESERVED_VAL;
   end

   // ****************************************************************
   // Flag storage
   // ****************************************************************
   // One sticky cell per flag position, others read constant
   for (genvar i = 0; i < 16; i++) begin : g_bit
      if (PCSR_FLAG_MASK[i]) begin : g_flag
         pcsr_flag_cell u_cell (
            .core_clk (core_clk),
            .arst_n   (arst_n),
            .set      (set_vec[i]),
            .clr      (clr_vec[i]),
            .flag_q   (flags[i])
         );
      end else begin : g_none
         assign flags[i] = 1'b0;
      end
   end

   // Next register view, flag cells merged with fixed fields
   assign status_d = (flags & PCSR_FLAG_MASK) | (fixed_bits & PCSR_FIXED_MASK);

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Registered copy of the register contents
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status_word_q <= PCSR_STATUS_RESET;
      end else begin
         status_word_q <= status_d;
      end
   end

   // Read answer, unmapped addresses return zero
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_rvalid_q <= 1'b0;
         cfg_rdata_q  <= 16'h0000;
      end else begin
         cfg_rvalid_q <= cfg_req.rd;
         if (cfg_req.rd) begin
            cfg_rdata_q <= hit ? status_word_q : 16'h0000;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence s_clear_write(int b);
      cfg_req.wr && hit && cfg_req.byte_en[1] && cfg_req.wdata[b];
   endsequence

   sequence s_no_clear(int b);
      !(cfg_req.wr && hit && cfg_req.byte_en[1] && cfg_req.wdata[b]);
   endsequence

   a_parity_flag_set: assert property (
      (events.addr_parity_err || events.data_parity_err) |-> ##2 status_word_q[15])
      else $error("parity event did not set bit 15");

   a_serr_gated: assert property (
      $rose(flags[PCSR_BIT_SIGNALED_SERR]) |->
         $past(events.serr_signaled && system_error_enable))
      else $error("bit 14 rose without enabled system error");

   a_received_master_abort_flag_set: assert property (
      events.master_abort |=> flags[PCSR_BIT_RCVD_RECEIVED_MASTER_ABORT_FLAG])
      else $error("master abort did not set bit 13");

   a_tabort_rcvd: assert property (
      events.target_abort_rcvd |=> flags[PCSR_BIT_RCVD_TABORT])
      else $error("received target abort did not set bit 12");

   a_tabort_sig: assert property (
      events.target_abort_sig |-> ##2 status_word_q[PCSR_BIT_SIG_TABORT])
      else $error("signaled target abort did not set bit 11");

   a_dpar_conditions: assert property (
      $rose(flags[PCSR_BIT_MASTER_DPAR]) |->
         $past(events.perr_seen && events.bus_master_xfer && parity_response_enable))
      else $error("bit 8 rose without all three conditions");

   a_fixed_fields: assert property (
      (status_word_q & PCSR_FIXED_MASK) == 16'h0210)
      else $error("hardwired fields differ from 0210h pattern");

   a_clear_takes: assert property (
      s_clear_write(PCSR_BIT_RCVD_RECEIVED_MASTER_ABORT_FLAG) and !events.master_abort
         |-> ##2 !status_word_q[PCSR_BIT_RCVD_RECEIVED_MASTER_ABORT_FLAG])
      else $error("write one did not clear bit 13");

   a_zero_keeps: assert property (
      (flags[PCSR_BIT_SIG_TABORT] and s_no_clear(PCSR_BIT_SIG_TABORT))
         |=> flags[PCSR_BIT_SIG_TABORT])
      else $error("bit 11 dropped without a write of one");

   a_set_wins: assert property (
      s_clear_write(PCSR_BIT_DETECTED_PARITY) and events.data_parity_err
         |=> flags[PCSR_BIT_DETECTED_PARITY])
      else $error("clear beat a simultaneous parity event");

   a_read_answer: assert property (
      cfg_req.rd && hit |=> cfg_rvalid_q && (cfg_rdata_q == $past(status_word_q)))
      else $error("status read answer wrong or late");

   a_serr_sets: assert property (
      events.serr_signaled && system_error_enable |=> flags[PCSR_BIT_SIGNALED_SERR])
      else $error("enabled system error did not set bit 14");

   a_dpar_sets: assert property (
      events.perr_seen && events.bus_master_xfer && parity_response_enable
         |=> flags[PCSR_BIT_MASTER_DPAR])
      else $error("qualified data parity error did not set bit 8");

   a_parity_clear: assert property (
      s_clear_write(PCSR_BIT_DETECTED_PARITY) and !events.addr_parity_err
         and !events.data_parity_err |=> !flags[PCSR_BIT_DETECTED_PARITY])
      else $error("write one did not clear bit 15");

   a_reserved_zero: assert property (
      (status_word_q[3:0] == 4'h0) && (cfg_rdata_q[3:0] == 4'h0))
      else $error("reserved bits read nonzero");

   a_devsel_read: assert property (
      cfg_req.rd && hit |=> cfg_rdata_q[10:9] == PCSR_DEVSEL_MEDIUM)
      else $error("select timing field read wrong");

endmodule : pcsr_status_reg

// ---- verification/pcsr_host_model.sv ----
// Purpose: Host bridge model issuing configuration reads and writes
// Assumes: Tasks are entered just after a rising edge of core_clk
// Notes:   Released address and data lines show inverted values, not the old ones
module pcsr_host_model (
   // Clock
   input  wire logic               core_clk,
   // Request and command enables
   output pcsr_pkg::pcsr_cfg_req_t cfg_req,
   output logic                    system_error_enable,
   output logic                    parity_response_enable,
   // Answer
   input  wire logic               cfg_rvalid_q,
   input  wire logic [15:0]        cfg_rdata_q
);
   timeunit 1ns;
   timeprecision 1ps;
   import pcsr_pkg::*;

   // Idle bus at time zero
   initial begin
      cfg_req                = '0;
      system_error_enable    = 1'b0;
      parity_response_enable = 1'b0;
   end

   // Command enables as host software programs them
   task automatic set_enables(input logic se, input logic pe);
      system_error_enable    = se;
      parity_response_enable = pe;
   endtask : set_enables

   // Drop strobes, scramble the released lines
   task automatic release_bus();
      cfg_req.rd    = 1'b0;
      cfg_req.wr    = 1'b0;
      cfg_req.addr  = ~cfg_req.addr;
      cfg_req.wdata = ~cfg_req.wdata;
   endtask : release_bus

   // One write cycle, ones clear flags
   task automatic cfg_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      cfg_req.addr    = a;
      cfg_req.byte_en = be;
      cfg_req.wdata   = d;
      cfg_req.wr      = 1'b1;
      @(posedge core_clk);
      #1;
      release_bus();
   endtask : cfg_write

   // One read cycle, answer taken 1 ns after the edge that samples the strobe
   task automatic cfg_read(input logic [7:0] a, output logic [15:0] d, output logic v);
      cfg_req.addr = a;
      cfg_req.rd   = 1'b1;
      @(posedge core_clk);
      #1;
      release_bus();
      v = cfg_rvalid_q;
      d = cfg_rdata_q;
   endtask : cfg_read
endmodule : pcsr_host_model

// ---- verification/tb_top.sv ----
// Purpose: Random and corner-case bench for the status register bank
// Assumes: Host model drives config cycles, bench drives bus events
// Notes:   Expected flags tracked by a bench-side model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pcsr_pkg::*;

   logic          core_clk = 1'b0;
   logic          arst_n   = 1'b0;
   logic          se, pe, rvalid, v;
   pcsr_event_t   ev = '0;
   pcsr_cfg_req_t req;
   logic [15:0]   rdata, word, d, exp_q, wd;
   logic [7:0]    a;
   logic [1:0]    be;
   logic          do_wr;
   logic          se_r, pe_r;
   int            seed = 54214;
   int            mismatches = 0;
   int            n_checks = 0;
   int            cycles = 0;

   pcsr_host_model host (.core_clk(core_clk), .cfg_req(req), .system_error_enable(se),
      .parity_response_enable(pe), .cfg_rvalid_q(rvalid), .cfg_rdata_q(rdata));
   pcsr_status_reg dut (.core_clk(core_clk), .arst_n(arst_n), .system_error_enable(se),
      .parity_response_enable(pe), .events(ev), .cfg_req(req), .cfg_rvalid_q(rvalid),
      .cfg_rdata_q(rdata), .status_word_q(word));

   // Clock and hang guard
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // Next flag state from events, enables and a host write
   function automatic logic [15:0] next_flags(logic [15:0] f, pcsr_event_t e, logic s,
      logic p, logic w, logic [7:0] ad, logic [1:0] b, logic [15:0] wv);
      logic [15:0] set;
      logic [15:0] clr;
      set     = '0;
      set[15] = e.addr_parity_err | e.data_parity_err;
      set[14] = e.serr_signaled & s;
      set[13] = e.master_abort;
      set[12] = e.target_abort_rcvd;
      set[11] = e.target_abort_sig;
      set[8]  = e.perr_seen & e.bus_master_xfer & p;
      clr     = (w && ad[7:1] == 7'h03 && b[1]) ? (wv & 16'hF900) : 16'h0000;
      return (f & ~clr) | set;
   endfunction : next_flags

   // Mapped, neighbour or random address
   function automatic logic [7:0] pick_addr();
      int k;
      k = $unsigned($random(seed)) % 4;
      return (k == 0) ? 8'h06 : (k == 1) ? 8'h07 : 8'($random(seed));
   endfunction : pick_addr

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Read an address and compare against the model
   task automatic read_cmp(input logic [7:0] ad);
      host.cfg_read(ad, d, v);
      check("rvalid", {15'h0000, v}, 16'h0001);
      check("rdata", d, (ad[7:1] == 7'h03) ? (exp_q | 16'h0210) : 16'h0000);
   endtask : read_cmp

   task automatic do_reset();
      arst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      exp_q  = '0;
      check("reset word", word, 16'h0210);
      read_cmp(8'h06);
   endtask : do_reset

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   // Random event and clear traffic with reads after each step
   initial begin
      do_reset();
      for (int i = 0; i < 400; i++) begin
         if (i == 200) do_reset();
         @(posedge core_clk);
         #1;
         se_r  = 1'($random(seed));
         pe_r  = 1'($random(seed));
         host.set_enables(se_r, pe_r);
         ev    = (i % 3 == 0) ? pcsr_event_t'(8'hFF) : pcsr_event_t'(8'($random(seed)));
         a     = pick_addr();
         be    = 2'($random(seed));
         wd    = (i % 5 == 0) ? 16'hFFFF : 16'($random(seed));
         do_wr = (i % 4 != 1);
         exp_q = next_flags(exp_q, ev, se_r, pe_r, do_wr, a, be, wd);
         fork
            if (do_wr) host.cfg_write(a, be, wd);
            begin
               @(posedge core_clk);
               #1;
               ev = '0;
            end
         join
         repeat (2) @(posedge core_clk);
         #1;
         read_cmp(pick_addr());
         check("status word", word, exp_q | 16'h0210);
      end
      tally_and_finish();
   end
endmodule : tb_top
